// ===== inc/fp_decode_pkg.sv
// field layout, codes and decoded carriers for the coprocessor decoder
package fp_decode_pkg;

	// instruction word fields
	localparam int CLASS_HI = 27;
	localparam int CLASS_LO = 24;
	localparam int XCLASS_HI = 27;
	localparam int XCLASS_LO = 25;
	localparam int CPNUM_HI = 11;
	localparam int CPNUM_LO = 8;
	localparam int OPC_HI = 23;
	localparam int OPC_LO = 20;
	localparam int MONADIC_BIT = 15;
	localparam int PREC_HI_BIT = 19;
	localparam int PREC_LO_BIT = 7;
	localparam int RND_HI = 6;
	localparam int RND_LO = 5;
	localparam int CDP_ZERO_BIT = 4;
	localparam int CONST_BIT = 3;
	localparam int FN_HI = 18;
	localparam int FN_LO = 16;
	localparam int FD_HI = 14;
	localparam int FD_LO = 12;
	localparam int FM_HI = 2;
	localparam int FM_LO = 0;
	localparam int PRE_BIT = 24;
	localparam int UP_BIT = 23;
	localparam int LEN_HI_BIT = 22;
	localparam int WB_BIT = 21;
	localparam int LOAD_BIT = 20;
	localparam int BASE_HI = 19;
	localparam int BASE_LO = 16;
	localparam int LEN_LO_BIT = 15;
	localparam int OFS_HI = 7;
	localparam int OFS_LO = 0;

	localparam logic [3:0] DATA_OP_CLASS = 4'h_e;
	localparam logic [2:0] XFER_CLASS = 3'h_6;
	localparam logic [3:0] CP_MAIN = 4'h_1;
	localparam logic [3:0] CP_MULTI = 4'h_2;
	localparam logic [1:0] LEN_EXTENDED = 2'h_2;

	// opcode with the monadic flag appended
	localparam logic [4:0] OP_ADD = 5'h_00;
	localparam logic [4:0] OP_MUL = 5'h_02;
	localparam logic [4:0] OP_SUB = 5'h_04;
	localparam logic [4:0] OP_RSB = 5'h_06;
	localparam logic [4:0] OP_DIV = 5'h_08;
	localparam logic [4:0] OP_RDV = 5'h_0a;
	localparam logic [4:0] OP_POW = 5'h_0c;
	localparam logic [4:0] OP_RPW = 5'h_0e;
	localparam logic [4:0] OP_REM = 5'h_10;
	localparam logic [4:0] OP_FMUL = 5'h_12;
	localparam logic [4:0] OP_FDIV = 5'h_14;
	localparam logic [4:0] OP_FRDV = 5'h_16;
	localparam logic [4:0] OP_POL = 5'h_18;
	localparam logic [4:0] OP_RSV0 = 5'h_1a;
	localparam logic [4:0] OP_RSV1 = 5'h_1c;
	localparam logic [4:0] OP_RSV2 = 5'h_1e;
	localparam logic [4:0] OP_MOV = 5'h_01;
	localparam logic [4:0] OP_MNEG = 5'h_03;
	localparam logic [4:0] OP_ABS = 5'h_05;
	localparam logic [4:0] OP_RND = 5'h_07;
	localparam logic [4:0] OP_SQRT = 5'h_09;
	localparam logic [4:0] OP_TRANS_FIRST = 5'h_0b;
	localparam logic [4:0] OP_TRANS_LAST = 5'h_1b;
	localparam logic [4:0] OP_URND = 5'h_1d;
	localparam logic [4:0] OP_NORM = 5'h_1f;

	localparam logic [2:0] CNT_FOUR = 3'h_4;

	// single precision images of the constant table
	localparam logic [31:0] K_0_0 = 32'h_0000_0000;
	localparam logic [31:0] K_1_0 = 32'h_3f80_0000;
	localparam logic [31:0] K_2_0 = 32'h_4000_0000;
	localparam logic [31:0] K_3_0 = 32'h_4040_0000;
	localparam logic [31:0] K_4_0 = 32'h_4080_0000;
	localparam logic [31:0] K_5_0 = 32'h_40a0_0000;
	localparam logic [31:0] K_0_5 = 32'h_3f00_0000;
	localparam logic [31:0] K_10_0 = 32'h_4120_0000;

	typedef enum logic [4:0] {
		OPK_NONE, OPK_ADD, OPK_MUL, OPK_SUB, OPK_RSB, OPK_DIV, OPK_RDV,
		OPK_REM, OPK_MOV, OPK_MNEG, OPK_ABS, OPK_RND, OPK_SQRT,
		OPK_URND, OPK_NORM
	} op_kind_type;

	typedef enum logic [1:0] {
		PREC_SINGLE, PREC_DOUBLE, PREC_EXTENDED, PREC_BAD
	} precision_type;

	typedef enum logic [1:0] {
		RND_NEAREST, RND_PLUS_INF, RND_MINUS_INF, RND_ZERO
	} round_mode_type;

	typedef enum logic [1:0] {
		STACK_NONE, STACK_EMPTY_ASC, STACK_FULL_DESC
	} stack_form_type;

	typedef struct packed {
		op_kind_type op;
		logic monadic;
		logic single_only;
		logic unnorm_result;
		precision_type result_precision;
		round_mode_type round_mode;
		round_mode_type step_round_mode;
		logic [2:0] dest_float_reg;
		logic [2:0] first_operand_reg;
		logic [2:0] second_operand_reg;
		logic const_sel;
		logic [31:0] const_value;
	} data_dec_type;

	typedef struct packed {
		logic load;
		logic pre_index;
		logic addr_up;
		logic base_update_bit;
		logic [3:0] base_int_reg;
		logic [2:0] first_reg;
		logic [2:0] reg_count;
		logic [7:0] word_offset;
		stack_form_type stack;
		logic raw_copy;
	} xfer_dec_type;

endpackage : fp_decode_pkg

// ===== core/fp_const_rom.sv
// constant operand table selected by the second-operand field
module fp_const_rom (
	// selection
	input wire logic [2:0] i_sel,
	// constant image
	output logic [31:0] o_value
);

	always_comb begin
		unique case (i_sel)
			3'h_0: o_value = fp_decode_pkg::K_0_0;
			3'h_1: o_value = fp_decode_pkg::K_1_0;
			3'h_2: o_value = fp_decode_pkg::K_2_0;
			3'h_3: o_value = fp_decode_pkg::K_3_0;
			3'h_4: o_value = fp_decode_pkg::K_4_0;
			3'h_5: o_value = fp_decode_pkg::K_5_0;
			3'h_6: o_value = fp_decode_pkg::K_0_5;
			3'h_7: o_value = fp_decode_pkg::K_10_0;
		endcase
	end

endmodule : fp_const_rom

// ===== core/fp_coproc_data_op_decode.sv
// registered decoder for coprocessor data operations and multiple transfers
module fp_coproc_data_op_decode (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// instruction from the integer core
	input wire logic I_INSTR_VALID,
	input wire logic [31:0] I_INSTR,
	// decode result
	output logic O_DEC_VALID,
	output logic O_IS_DATA_OP,
	output logic O_IS_XFER,
	output logic O_UNDEF_TRAP,
	output fp_decode_pkg::data_dec_type O_DATA_DEC,
	output fp_decode_pkg::xfer_dec_type O_XFER_DEC
);

	logic [31:0] ins;
	logic is_data;
	logic is_multi;
	logic is_ext_single;
	logic is_xfer;
	logic [4:0] opc;
	logic trap;
	logic [31:0] rom_value;
	fp_decode_pkg::data_dec_type data_next;
	fp_decode_pkg::xfer_dec_type xfer_next;

	function automatic logic [3:0] cp_field(input logic [31:0] w);
		cp_field = w[fp_decode_pkg::CPNUM_HI:fp_decode_pkg::CPNUM_LO];
	endfunction : cp_field

	function automatic logic [1:0] len_field(input logic [31:0] w);
		len_field = {w[fp_decode_pkg::LEN_HI_BIT],
			w[fp_decode_pkg::LEN_LO_BIT]};
	endfunction : len_field

	function automatic logic is_xfer_class(input logic [31:0] w);
		is_xfer_class =
			w[fp_decode_pkg::XCLASS_HI:fp_decode_pkg::XCLASS_LO] ==
			fp_decode_pkg::XFER_CLASS;
	endfunction : is_xfer_class

	assign ins = I_INSTR;

	assign is_data = I_INSTR_VALID &&
		ins[fp_decode_pkg::CLASS_HI:fp_decode_pkg::CLASS_LO] ==
		fp_decode_pkg::DATA_OP_CLASS &&
		cp_field(ins) == fp_decode_pkg::CP_MAIN &&
		!ins[fp_decode_pkg::CDP_ZERO_BIT];

	assign is_multi = I_INSTR_VALID && is_xfer_class(ins) &&
		cp_field(ins) == fp_decode_pkg::CP_MULTI;

	// extended single transfers also move the internal form verbatim
	assign is_ext_single = I_INSTR_VALID && is_xfer_class(ins) &&
		cp_field(ins) == fp_decode_pkg::CP_MAIN &&
		len_field(ins) == fp_decode_pkg::LEN_EXTENDED;

	assign is_xfer = is_multi || is_ext_single;

	assign opc = {ins[fp_decode_pkg::OPC_HI:fp_decode_pkg::OPC_LO],
		ins[fp_decode_pkg::MONADIC_BIT]};

	fp_const_rom const_rom (
		.i_sel(ins[fp_decode_pkg::FM_HI:fp_decode_pkg::FM_LO]),
		.o_value(rom_value)
	);

	// data operation field decode
	always_comb begin
		data_next = '0;
		trap = 1'b0;
		data_next.monadic = ins[fp_decode_pkg::MONADIC_BIT];
		data_next.dest_float_reg = ins[fp_decode_pkg::FD_HI:fp_decode_pkg::FD_LO];
		data_next.first_operand_reg =
			ins[fp_decode_pkg::FN_HI:fp_decode_pkg::FN_LO];
		data_next.second_operand_reg =
			ins[fp_decode_pkg::FM_HI:fp_decode_pkg::FM_LO];
		data_next.const_sel = ins[fp_decode_pkg::CONST_BIT];
		data_next.const_value = ins[fp_decode_pkg::CONST_BIT] ? rom_value : '0;
		// the field is mandatory, so 11 is a trap, not a default
		unique case ({ins[fp_decode_pkg::PREC_HI_BIT],
			ins[fp_decode_pkg::PREC_LO_BIT]})
			2'b00: data_next.result_precision = fp_decode_pkg::PREC_SINGLE;
			2'b01: data_next.result_precision = fp_decode_pkg::PREC_DOUBLE;
			2'b10: data_next.result_precision = fp_decode_pkg::PREC_EXTENDED;
			2'b11: begin
				data_next.result_precision = fp_decode_pkg::PREC_BAD;
				trap = 1'b1;
			end
		endcase
		unique case (ins[fp_decode_pkg::RND_HI:fp_decode_pkg::RND_LO])
			2'b00: data_next.round_mode = fp_decode_pkg::RND_NEAREST;
			2'b01: data_next.round_mode = fp_decode_pkg::RND_PLUS_INF;
			2'b10: data_next.round_mode = fp_decode_pkg::RND_MINUS_INF;
			2'b11: data_next.round_mode = fp_decode_pkg::RND_ZERO;
		endcase
		// multi-step sequences run at nearest; only the last step is
		// directed, and those sequences are all emulated here anyway
		data_next.step_round_mode = fp_decode_pkg::RND_NEAREST;
		unique case (opc)
			fp_decode_pkg::OP_ADD: data_next.op = fp_decode_pkg::OPK_ADD;
			fp_decode_pkg::OP_MUL: data_next.op = fp_decode_pkg::OPK_MUL;
			fp_decode_pkg::OP_SUB: data_next.op = fp_decode_pkg::OPK_SUB;
			fp_decode_pkg::OP_RSB: data_next.op = fp_decode_pkg::OPK_RSB;
			fp_decode_pkg::OP_DIV: data_next.op = fp_decode_pkg::OPK_DIV;
			fp_decode_pkg::OP_RDV: data_next.op = fp_decode_pkg::OPK_RDV;
			fp_decode_pkg::OP_REM: data_next.op = fp_decode_pkg::OPK_REM;
			// fast forms share the normal datapath: no speed promised
			fp_decode_pkg::OP_FMUL: begin
				data_next.op = fp_decode_pkg::OPK_MUL;
				data_next.single_only = 1'b1;
			end
			fp_decode_pkg::OP_FDIV: begin
				data_next.op = fp_decode_pkg::OPK_DIV;
				data_next.single_only = 1'b1;
			end
			fp_decode_pkg::OP_FRDV: begin
				data_next.op = fp_decode_pkg::OPK_RDV;
				data_next.single_only = 1'b1;
			end
			fp_decode_pkg::OP_POW,
			fp_decode_pkg::OP_RPW,
			fp_decode_pkg::OP_POL: trap = 1'b1;
			fp_decode_pkg::OP_RSV0,
			fp_decode_pkg::OP_RSV1,
			fp_decode_pkg::OP_RSV2: trap = 1'b1;
			fp_decode_pkg::OP_MOV: data_next.op = fp_decode_pkg::OPK_MOV;
			fp_decode_pkg::OP_MNEG: data_next.op = fp_decode_pkg::OPK_MNEG;
			fp_decode_pkg::OP_ABS: data_next.op = fp_decode_pkg::OPK_ABS;
			fp_decode_pkg::OP_RND: data_next.op = fp_decode_pkg::OPK_RND;
			fp_decode_pkg::OP_SQRT: data_next.op = fp_decode_pkg::OPK_SQRT;
			fp_decode_pkg::OP_URND: begin
				data_next.op = fp_decode_pkg::OPK_URND;
				data_next.unnorm_result = 1'b1;
			end
			fp_decode_pkg::OP_NORM: data_next.op = fp_decode_pkg::OPK_NORM;
			default: begin
				// odd codes 01011 to 11011 are the transcendental set
				trap = 1'b1;
			end
		endcase
		if (trap) begin
			data_next.op = fp_decode_pkg::OPK_NONE;
			data_next.single_only = 1'b0;
			data_next.unnorm_result = 1'b0;
		end
	end

	// transfer field decode
	always_comb begin
		xfer_next = '0;
		xfer_next.load = ins[fp_decode_pkg::LOAD_BIT];
		xfer_next.pre_index = ins[fp_decode_pkg::PRE_BIT];
		// direction follows the up bit, which the stack form already set
		xfer_next.addr_up = ins[fp_decode_pkg::UP_BIT];
		// the update bit is used as encoded, never implied
		xfer_next.base_update_bit = ins[fp_decode_pkg::WB_BIT];
		xfer_next.base_int_reg = ins[fp_decode_pkg::BASE_HI:fp_decode_pkg::BASE_LO];
		xfer_next.first_reg = ins[fp_decode_pkg::FD_HI:fp_decode_pkg::FD_LO];
		// word count scaled by four later gives at most 1020 bytes
		xfer_next.word_offset = ins[fp_decode_pkg::OFS_HI:fp_decode_pkg::OFS_LO];
		xfer_next.raw_copy = 1'b1;
		if (is_multi) begin
			unique case (len_field(ins))
				2'b00: xfer_next.reg_count = fp_decode_pkg::CNT_FOUR;
				default: xfer_next.reg_count = {1'b0, len_field(ins)};
			endcase
		end else begin
			xfer_next.reg_count = 3'h_1;
		end
		// full stacks pre-index on stores, empty ones on loads; the rest post-index
		unique case ({ins[fp_decode_pkg::LOAD_BIT], ins[fp_decode_pkg::PRE_BIT],
			ins[fp_decode_pkg::UP_BIT]})
			3'b101: xfer_next.stack = fp_decode_pkg::STACK_FULL_DESC;
			3'b110: xfer_next.stack = fp_decode_pkg::STACK_EMPTY_ASC;
			3'b001: xfer_next.stack = fp_decode_pkg::STACK_EMPTY_ASC;
			3'b010: xfer_next.stack = fp_decode_pkg::STACK_FULL_DESC;
			// other mixes are plain indexed forms
			default: xfer_next.stack = fp_decode_pkg::STACK_NONE;
		endcase
	end

	// decode strobe follows valid with a fixed latency of one
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_DEC_VALID <= 1'b0;
		end else begin
			O_DEC_VALID <= I_INSTR_VALID;
		end
	end

	// class flags
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_IS_DATA_OP <= 1'b0;
			O_IS_XFER <= 1'b0;
		end else begin
			O_IS_DATA_OP <= is_data;
			O_IS_XFER <= is_xfer;
		end
	end

	// trap pulse; transfers never trap, so only data ops feed it
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_UNDEF_TRAP <= 1'b0;
		end else begin
			O_UNDEF_TRAP <= is_data && trap;
		end
	end

	// decoded fields, zero when not of that class
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_DATA_DEC <= '0;
			O_XFER_DEC <= '0;
		end else begin
			O_DATA_DEC <= is_data ? data_next : '0;
			O_XFER_DEC <= is_xfer ? xfer_next : '0;
		end
	end

endmodule : fp_coproc_data_op_decode

// ===== verif/fp_decode_asserts.sv
// port-level assertions for the coprocessor decoder
module fp_decode_asserts (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// instruction
	input wire logic I_INSTR_VALID,
	input wire logic [31:0] I_INSTR,
	// decode result
	input wire logic O_DEC_VALID,
	input wire logic O_IS_DATA_OP,
	input wire logic O_IS_XFER,
	input wire logic O_UNDEF_TRAP,
	input wire fp_decode_pkg::data_dec_type O_DATA_DEC,
	input wire fp_decode_pkg::xfer_dec_type O_XFER_DEC
);
	timeunit 1ns;
	timeprecision 1ps;
	logic dop;
	logic mx;
	logic [4:0] c;
	logic [2:0] lpu;
	assign c = {I_INSTR[23:20], I_INSTR[15]};
	assign lpu = {I_INSTR[20], I_INSTR[24], I_INSTR[23]};
	// a word met while reset is still low is dropped, not taken
	assign dop = I_RST_N && I_INSTR_VALID && I_INSTR[27:24] == 4'h_e
		&& I_INSTR[11:8] == 4'h_1 && !I_INSTR[4];
	assign mx = I_RST_N && I_INSTR_VALID && I_INSTR[27:25] == 3'h_6
		&& I_INSTR[11:8] == 4'h_2;
	default clocking dc @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	chk_valid_echo: assert property (I_RST_N && I_INSTR_VALID |=> O_DEC_VALID)
		else $error("decode valid missing");
	chk_idle_quiet: assert property (!O_DEC_VALID |-> !O_IS_DATA_OP
		&& !O_IS_XFER && !O_UNDEF_TRAP && O_DATA_DEC == '0 && O_XFER_DEC == '0)
		else $error("outputs not zero while idle");
	chk_data_class: assert property (dop |=> O_IS_DATA_OP)
		else $error("data op not flagged");
	chk_prec_trap: assert property (dop && I_INSTR[19] && I_INSTR[7]
		|=> O_UNDEF_TRAP && O_DATA_DEC.op == fp_decode_pkg::OPK_NONE)
		else $error("bad precision not trapped");
	chk_deprec_trap: assert property (dop && c inside {5'h_0c, 5'h_0e, 5'h_18}
		|=> O_UNDEF_TRAP) else $error("deprecated dyadic not trapped");
	chk_trans_trap: assert property (dop && c[0] && c >= 5'h_0b
		&& c <= 5'h_1b |=> O_UNDEF_TRAP) else $error("monadic not trapped");
	chk_rsv_trap: assert property (dop && c inside {5'h_1a, 5'h_1c, 5'h_1e}
		|=> O_UNDEF_TRAP) else $error("spare dyadic not trapped");
	chk_trap_source: assert property (O_UNDEF_TRAP |-> O_IS_DATA_OP)
		else $error("trap outside data op");
	chk_round_pass: assert property (dop
		|=> O_DATA_DEC.round_mode == $past(I_INSTR[6:5])
		&& O_DATA_DEC.step_round_mode == fp_decode_pkg::RND_NEAREST)
		else $error("rounding field wrong");
	chk_urnd_mark: assert property (dop && c == 5'h_1d && !I_INSTR[19]
		|=> O_DATA_DEC.unnorm_result) else $error("unnormalized flag missing");
	chk_stack_desc: assert property (mx && lpu inside {3'h_5, 3'h_2}
		|=> O_XFER_DEC.stack == fp_decode_pkg::STACK_FULL_DESC)
		else $error("descending stack not seen");
	chk_raw_keep: assert property (O_IS_XFER |-> O_XFER_DEC.raw_copy)
		else $error("raw copy not marked");
	cov_trap: cover property (dop ##1 O_UNDEF_TRAP);
	cov_asc: cover property (O_XFER_DEC.stack == fp_decode_pkg::STACK_EMPTY_ASC);
	cov_burst: cover property (I_INSTR_VALID [*3]);
endmodule : fp_decode_asserts

bind fp_coproc_data_op_decode fp_decode_asserts u_chk (.I_CLK(I_CLK),
	.I_RST_N(I_RST_N), .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR),
	.O_DEC_VALID(O_DEC_VALID), .O_IS_DATA_OP(O_IS_DATA_OP),
	.O_IS_XFER(O_IS_XFER), .O_UNDEF_TRAP(O_UNDEF_TRAP),
	.O_DATA_DEC(O_DATA_DEC), .O_XFER_DEC(O_XFER_DEC));

// ===== verif/fp_host_core_model.sv
// host core model issuing coprocessor words to the decoder
module fp_host_core_model (
	// clock
	input wire logic i_clk,
	// instruction to the decoder
	output logic o_valid,
	output logic [31:0] o_instr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_valid = 1'b0;
		o_instr = 32'h_0000_0000;
	end
	// one word per call, launched after the edge and held a full cycle
	task automatic issue(input logic v, input logic [31:0] w);
		@(posedge i_clk);
		o_valid <= v;
		o_instr <= w;
	endtask : issue
	// only the two legal stack forms can be asked for
	function automatic logic [31:0] stack_word(input logic ld,
		input logic ea, input logic [3:0] rn, input logic [2:0] fd,
		input logic [2:0] cnt);
		logic pre;
		logic up;
		logic [3:0] base;
		pre = ea ? ld : !ld;
		up = ea ? !ld : ld;
		base = (rn == 4'h_f) ? 4'h_0 : rn;
		// writeback always set, so post-indexed forms carry it too
		return {4'h_e, 3'h_6, pre, up, cnt[1], 1'b1, ld, base,
			cnt[0], fd, 4'h_2, 8'(3 * cnt)};
	endfunction : stack_word
endmodule : fp_host_core_model

// ===== verif/fp_coproc_data_op_decode_tb_top.sv
// self-checking bench for the coprocessor decoder
module fp_coproc_data_op_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic dv;
		logic dop;
		logic xf;
		logic tr;
		fp_decode_pkg::data_dec_type d;
		fp_decode_pkg::xfer_dec_type x;
	} exp_type;
	localparam logic [31:0] ktab [8] = '{fp_decode_pkg::K_0_0,
		fp_decode_pkg::K_1_0, fp_decode_pkg::K_2_0, fp_decode_pkg::K_3_0,
		fp_decode_pkg::K_4_0, fp_decode_pkg::K_5_0, fp_decode_pkg::K_0_5,
		fp_decode_pkg::K_10_0};
	localparam logic [31:0] odd_w [6] = '{32'h_0e10_0180, 32'h_0e00_0100,
		32'h_0e00_0210, 32'h_0e00_0110, 32'h_0f00_0100, 32'h_edc0_0104};
	logic clk;
	logic rst_n;
	logic valid;
	logic [31:0] instr;
	logic dv;
	logic dop_o;
	logic xf_o;
	logic tr_o;
	fp_decode_pkg::data_dec_type dd;
	fp_decode_pkg::xfer_dec_type xd;
	exp_type seen;
	exp_type expq [$];
	int miscompares;
	int tests_run;
	integer seed;
	logic mon_on;
	logic [31:0] r;
	assign seen = {dv, dop_o, xf_o, tr_o, dd, xd};
	fp_host_core_model host (.i_clk(clk), .o_valid(valid), .o_instr(instr));
	fp_coproc_data_op_decode uut (.I_CLK(clk), .I_RST_N(rst_n),
		.I_INSTR_VALID(valid), .I_INSTR(instr), .O_DEC_VALID(dv),
		.O_IS_DATA_OP(dop_o), .O_IS_XFER(xf_o), .O_UNDEF_TRAP(tr_o),
		.O_DATA_DEC(dd), .O_XFER_DEC(xd));
	function automatic fp_decode_pkg::op_kind_type op_of(input logic [4:0] c);
		case (c)
			5'h_00: return fp_decode_pkg::OPK_ADD;
			5'h_02, 5'h_12: return fp_decode_pkg::OPK_MUL;
			5'h_04: return fp_decode_pkg::OPK_SUB;
			5'h_06: return fp_decode_pkg::OPK_RSB;
			5'h_08, 5'h_14: return fp_decode_pkg::OPK_DIV;
			5'h_0a, 5'h_16: return fp_decode_pkg::OPK_RDV;
			5'h_10: return fp_decode_pkg::OPK_REM;
			5'h_01: return fp_decode_pkg::OPK_MOV;
			5'h_03: return fp_decode_pkg::OPK_MNEG;
			5'h_05: return fp_decode_pkg::OPK_ABS;
			5'h_07: return fp_decode_pkg::OPK_RND;
			5'h_09: return fp_decode_pkg::OPK_SQRT;
			5'h_1d: return fp_decode_pkg::OPK_URND;
			5'h_1f: return fp_decode_pkg::OPK_NORM;
			default: return fp_decode_pkg::OPK_NONE;
		endcase
	endfunction : op_of
	function automatic exp_type exp_of(input logic [31:0] w);
		exp_type e;
		logic [4:0] c;
		logic tr;
		e = '0;
		c = {w[23:20], w[15]};
		tr = {w[19], w[7]} == 2'h_3 || c inside {5'h_0c, 5'h_0e, 5'h_18,
			5'h_1a, 5'h_1c, 5'h_1e}
			|| (c[0] && c >= 5'h_0b && c <= 5'h_1b);
		e.dv = 1'b1;
		e.dop = w[27:24] == 4'h_e && w[11:8] == 4'h_1 && !w[4];
		e.xf = w[27:25] == 3'h_6 && (w[11:8] == 4'h_2
			|| (w[11:8] == 4'h_1 && {w[22], w[15]} == 2'h_2));
		if (e.dop) begin
			e.tr = tr;
			e.d.op = tr ? fp_decode_pkg::OPK_NONE : op_of(c);
			e.d.monadic = w[15];
			e.d.single_only = !tr && c inside {5'h_12, 5'h_14, 5'h_16};
			e.d.unnorm_result = !tr && c == 5'h_1d;
			e.d.result_precision = fp_decode_pkg::precision_type'({w[19], w[7]});
			e.d.round_mode = fp_decode_pkg::round_mode_type'(w[6:5]);
			e.d.step_round_mode = fp_decode_pkg::RND_NEAREST;
			e.d.dest_float_reg = w[14:12];
			e.d.first_operand_reg = w[18:16];
			e.d.second_operand_reg = w[2:0];
			e.d.const_sel = w[3];
			e.d.const_value = w[3] ? ktab[w[2:0]] : 32'h_0000_0000;
		end
		if (e.xf) begin
			e.x = {w[20], w[24], w[23], w[21], w[19:16], w[14:12], 3'h_0,
				w[7:0], fp_decode_pkg::STACK_NONE, 1'b1};
			e.x.reg_count = (w[11:8] == 4'h_1) ? 3'h_1 : {1'b0, w[22], w[15]};
			if (e.x.reg_count == 3'h_0) e.x.reg_count = 3'h_4;
			if ({w[20], w[24], w[23]} inside {3'h_5, 3'h_2})
				e.x.stack = fp_decode_pkg::STACK_FULL_DESC;
			if ({w[20], w[24], w[23]} inside {3'h_6, 3'h_1})
				e.x.stack = fp_decode_pkg::STACK_EMPTY_ASC;
		end
		return e;
	endfunction : exp_of
	task automatic check(input exp_type got, input exp_type want);
		tests_run++;
		if (got !== want) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h want=%h", $time, got, want);
		end
	endtask : check
	task automatic send(input logic v, input logic [31:0] w);
		host.issue(v, w);
		if (v) expq.push_back(exp_of(w));
	endtask : send
	task automatic give_verdict();
		if (expq.size() != 0) miscompares++;
		if (miscompares == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// every result is matched to the oldest note once it appears
	always @(negedge clk) begin
		if (mon_on && dv === 1'b1) begin
			if (expq.size() == 0) check(seen, '0);
			else check(seen, expq.pop_front());
		end else if (mon_on) begin
			check(seen, '0);
		end
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		mon_on = 1'b0;
		miscompares = 0;
		tests_run = 0;
		seed = 19;
		@(posedge clk);
		mon_on = 1'b1;
		repeat (9) @(posedge clk);
		rst_n <= 1'b1;
		// all codes at all precisions, other fields random, random idles
		for (int i = 0; i < 128; i++) begin
			r = $random(seed);
			send(1'b1, {r[31:28], 4'h_e, i[4:1], i[6], r[18:16], i[0],
				r[14:12], 4'h_1, i[5], r[6:5], 1'b0, r[3:0]});
			if (r[9]) send(1'b0, r);
		end
		for (int i = 0; i < 6; i++) send(1'b1, odd_w[i]);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			send(1'b1, host.stack_word(i[0], i[1], r[3:0], r[6:4],
				3'(i[3:2]) + 3'h_1));
		end
		// unnormalized round result is stacked, restored, then normalized
		send(1'b1, 32'h_eee0_b101);
		send(1'b1, host.stack_word(1'b0, 1'b0, 4'h_d, 3'h_3, 3'h_1));
		send(1'b1, host.stack_word(1'b1, 1'b0, 4'h_d, 3'h_3, 3'h_1));
		send(1'b1, 32'h_eef0_b103);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			// post-indexed forms keep writeback; base is never the pc
			send(1'b1, {r[31:28], 3'h_6, i[1], i[0], r[22], r[21] | !i[1],
				i[2], 1'b0, r[18:12], 4'h_2, r[7:0]});
		end
		// reset wins over a word presented during it
		send(1'b0, 32'h_0000_0000);
		@(posedge clk);
		rst_n <= 1'b0;
		host.issue(1'b1, odd_w[1]);
		host.issue(1'b0, 32'h_0000_0000);
		rst_n <= 1'b1;
		send(1'b1, odd_w[0]);
		send(1'b0, 32'h_0000_0000);
		repeat (3) @(posedge clk);
		give_verdict();
	end
endmodule : fp_coproc_data_op_decode_tb_top
